// file: hdl/pctu_unit.sv
// pulse command table unit: table execution, carrier phase and gain state, axi4-lite regs
//
// Contract
// R1: a table entry starts playback and applies its gain and angle updates in one core cycle.
// R2: playback via an entry starts one cycle after issue, the direct playback op after two.
// R3: each gain and angle of an entry is either an absolute value or an increment, per value.
// R4: run_table_entry carries an index and executes exactly the entry that it selects.
// R5: a compiled program longer than 16384 instructions is rejected at compile.
// R6: the wave table holds up to 16000 slots, each addressed by its bound numeric index.
// R7: a slot index is both the entry's waveform reference and the target of sample writes.
// R8: the host loads the command table only after the program has been compiled.
// R9: running is refused when the called entry or its referenced slot is undefined.
// R10: compiling a program invalidates any loaded command table until it is reloaded.
// R11: applied gains and angles persist for later playbacks until an entry changes them.
// R12: an entry setting one channel's gain leaves the other channel's gain unchanged.
// R13: angles from table entries take precedence over manually configured angles.
// R14: with a table present, enabling the sequencer clears every carrier angle to zero.
// R15: angle increments accumulate with wrap-around over one full turn.
// R16: a step_carrier_phase increment takes effect when the preceding playback ends.
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module pctu_unit #(
	parameter int ENTRIES = pctu_pkg::ENTRY_DEPTH,
	parameter int SLOTS   = pctu_pkg::WAVE_SLOTS,
	parameter int FDEPTH  = pctu_pkg::FIFO_DEPTH
) (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [7:0]                 s_axi_awaddr,
	input  wire logic [2:0]                 s_axi_awprot,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [7:0]                 s_axi_araddr,
	input  wire logic [2:0]                 s_axi_arprot,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic                       instr_valid,
	input  wire pctu_pkg::pctu_op_e         instr_op,
	input  wire logic [pctu_pkg::OPND_W-1:0] instr_operand,
	output logic                            instr_ready,
	input  wire logic                       playback_done,
	output logic                            play_start,
	output logic [pctu_pkg::SLOT_W-1:0]     play_slot,
	output logic [15:0]                     first_channel_gain,
	output logic [15:0]                     second_channel_gain,
	output logic [15:0]                     first_channel_angle,
	output logic [15:0]                     second_channel_angle,
	output logic                            wave_wr_valid,
	input  wire logic                       wave_wr_ready,
	output logic [pctu_pkg::SLOT_W-1:0]     wave_wr_slot,
	output logic [31:0]                     wave_wr_sample
);
	import pctu_pkg::*;
	localparam int IW = $clog2(ENTRIES);
	localparam int FW = SLOT_W + 32;

	// bus and configuration state
	logic              aw_have_ff, w_have_ff, bvalid_ff, awready_ff, wready_ff;
	logic              arready_ff, rvalid_ff;
	logic [7:0]        aw_addr_ff;
	logic [31:0]       w_data_ff, rdata_ff;
	logic [3:0]        w_strb_ff;
	logic [1:0]        bresp_ff, rresp_ff;
	logic              nxt_aw_have, nxt_w_have, nxt_bvalid, nxt_awready, nxt_wready;
	logic              nxt_arready, nxt_rvalid;
	logic [7:0]        nxt_aw_addr;
	logic [31:0]       nxt_w_data, nxt_rdata;
	logic [3:0]        nxt_w_strb;
	logic [1:0]        nxt_bresp, nxt_rresp;
	logic              seq_en_ff, cmpd_ff, cmperr_ff, loaded_ff;
	logic              nxt_seq_en, nxt_cmpd, nxt_cmperr, nxt_loaded;
	logic [15:0]       proglen_ff, nxt_proglen;
	logic [31:0]       tblidx_ff, w0_ff, tgain_ff, tang_ff, wslot_ff, manang_ff;
	logic [31:0]       nxt_tblidx, nxt_w0, nxt_tgain, nxt_tang, nxt_wslot, nxt_manang;
	logic              wr_fire, rd_fire, is_wdata, do_compile, do_commit, do_bind, clr_refused;
	logic [31:0]       wmerge;
	// table and slot storage
	pctu_entry_s       tbl_mem [ENTRIES];
	logic [ENTRIES-1:0] ent_def_ff;
	logic [SLOTS-1:0]  slot_def_ff;
	// execution state
	logic              play_ff, ready_ff, refused_ff, dp_pend_ff, en_prev_ff;
	logic              nxt_play, nxt_ready, nxt_refused, nxt_dp_pend;
	logic [SLOT_W-1:0] pslot_ff, dp_slot_ff, nxt_pslot, nxt_dp_slot;
	logic [1:0][15:0]  gain_ff, angle_ff, step_ff, nxt_gain, nxt_angle, nxt_step;
	pctu_entry_s       ent;
	logic              run_acc, run_ok, dp_acc, dp_ok, ld_acc, st_acc, en_rise, ent_def;
	logic [15:0]       op_val;

	pctu_stream_if #(.W(FW)) fin ();
	pctu_stream_if #(.W(FW)) fout ();

	// byte-lane merge for partial writes
	function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++)
			if (s[b])
				r[8*b +: 8] = n[8*b +: 8];
		return r;
	endfunction

	// write path: address and data taken in either order, response once both held and, for sample data, the fifo has room
	always_comb
	begin
		is_wdata    = (aw_addr_ff == OFS_WDATA);
		wr_fire     = aw_have_ff & w_have_ff & ~bvalid_ff & (~is_wdata | fin.ready);
		nxt_aw_have = aw_have_ff ? ~wr_fire : (s_axi_awvalid & awready_ff);
		nxt_w_have  = w_have_ff ? ~wr_fire : (s_axi_wvalid & wready_ff);
		nxt_aw_addr = (s_axi_awvalid & awready_ff) ? s_axi_awaddr : aw_addr_ff;
		nxt_w_data  = (s_axi_wvalid & wready_ff) ? s_axi_wdata : w_data_ff;
		nxt_w_strb  = (s_axi_wvalid & wready_ff) ? s_axi_wstrb : w_strb_ff;
		nxt_awready = ~nxt_aw_have;
		nxt_wready  = ~nxt_w_have;
		nxt_bvalid  = wr_fire | (bvalid_ff & ~s_axi_bready);
		nxt_bresp   = bresp_ff;
		wmerge      = mrg(32'h0, w_data_ff, w_strb_ff);
		do_compile  = 1'b0;
		do_commit   = 1'b0;
		do_bind     = 1'b0;
		clr_refused = 1'b0;
		nxt_seq_en  = seq_en_ff;
		nxt_cmpd    = cmpd_ff;
		nxt_cmperr  = cmperr_ff;
		nxt_loaded  = loaded_ff;
		nxt_proglen = proglen_ff;
		nxt_tblidx  = tblidx_ff;
		nxt_w0      = w0_ff;
		nxt_tgain   = tgain_ff;
		nxt_tang    = tang_ff;
		nxt_wslot   = wslot_ff;
		nxt_manang  = manang_ff;
		if (wr_fire)
		begin
			nxt_bresp = RESP_OK;
			unique case (aw_addr_ff)
				OFS_CTRL:
				begin
					if (w_strb_ff[0])
					begin
						nxt_seq_en = w_data_ff[CTRL_EN];
						do_compile = w_data_ff[CTRL_CMP];
						if (w_data_ff[CTRL_LOAD] & cmpd_ff) // R8
							nxt_loaded = 1'b1;
						if (do_compile)
						begin
							nxt_cmpd   = 32'(proglen_ff) <= PROG_MAX_INSTR; // R5
							nxt_cmperr = 32'(proglen_ff) > PROG_MAX_INSTR; // R5
							nxt_loaded = 1'b0; // R10
						end
					end
				end
				OFS_STATUS:  clr_refused = wmerge[ST_REFUSED];
				OFS_PROGLEN: nxt_proglen = 16'(mrg({16'h0, proglen_ff}, w_data_ff, w_strb_ff));
				OFS_TBLIDX:  nxt_tblidx = mrg(tblidx_ff, w_data_ff, w_strb_ff);
				OFS_TBLW0:   nxt_w0 = mrg(w0_ff, w_data_ff, w_strb_ff);
				OFS_TBLGAIN: nxt_tgain = mrg(tgain_ff, w_data_ff, w_strb_ff);
				OFS_TBLANG:  nxt_tang = mrg(tang_ff, w_data_ff, w_strb_ff);
				OFS_COMMIT:  do_commit = tblidx_ff < 32'(ENTRIES);
				OFS_BIND:    do_bind = wmerge < 32'(SLOTS); // R6
				OFS_WSLOT:   nxt_wslot = mrg(wslot_ff, w_data_ff, w_strb_ff);
				OFS_WDATA:   nxt_bresp = RESP_OK;
				OFS_MANANG:  nxt_manang = mrg(manang_ff, w_data_ff, w_strb_ff);
				default:     nxt_bresp = RESP_ERR;
			endcase
		end
	end

	// read path: one read in flight, unmapped offsets answer slverr
	always_comb
	begin
		rd_fire     = s_axi_arvalid & arready_ff;
		nxt_rvalid  = rd_fire | (rvalid_ff & ~s_axi_rready);
		nxt_arready = ~nxt_rvalid;
		nxt_rdata   = rdata_ff;
		nxt_rresp   = rresp_ff;
		if (rd_fire)
		begin
			nxt_rresp = RESP_OK;
			nxt_rdata = 32'h0;
			unique case (s_axi_araddr)
				OFS_CTRL:    nxt_rdata[CTRL_EN] = seq_en_ff;
				OFS_STATUS:  nxt_rdata[3:0] = {cmperr_ff, refused_ff, loaded_ff, cmpd_ff};
				OFS_PROGLEN: nxt_rdata = {16'h0, proglen_ff};
				OFS_TBLIDX:  nxt_rdata = tblidx_ff;
				OFS_TBLW0:   nxt_rdata = w0_ff;
				OFS_TBLGAIN: nxt_rdata = tgain_ff;
				OFS_TBLANG:  nxt_rdata = tang_ff;
				OFS_WSLOT:   nxt_rdata = wslot_ff;
				OFS_GAINRB:  nxt_rdata = {gain_ff[1], gain_ff[0]};
				OFS_ANGRB:   nxt_rdata = {angle_ff[1], angle_ff[0]};
				OFS_MANANG:  nxt_rdata = manang_ff;
				OFS_COMMIT, OFS_BIND, OFS_WDATA: nxt_rdata = 32'h0;
				default:     nxt_rresp = RESP_ERR;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			{aw_have_ff, w_have_ff, bvalid_ff, rvalid_ff} <= 4'h0;
			{awready_ff, wready_ff, arready_ff} <= 3'h7;
			aw_addr_ff <= 8'h00;
			{w_data_ff, rdata_ff} <= 64'h0;
			w_strb_ff  <= 4'h0;
			{bresp_ff, rresp_ff} <= 4'h0;
			{seq_en_ff, cmpd_ff, cmperr_ff, loaded_ff} <= 4'h0;
			proglen_ff <= 16'h0000;
			{tblidx_ff, w0_ff, tgain_ff, tang_ff, wslot_ff, manang_ff} <= '0;
		end
		else
		begin
			{aw_have_ff, w_have_ff, bvalid_ff, rvalid_ff} <=
				{nxt_aw_have, nxt_w_have, nxt_bvalid, nxt_rvalid};
			{awready_ff, wready_ff, arready_ff} <= {nxt_awready, nxt_wready, nxt_arready};
			aw_addr_ff <= nxt_aw_addr;
			{w_data_ff, rdata_ff} <= {nxt_w_data, nxt_rdata};
			w_strb_ff  <= nxt_w_strb;
			{bresp_ff, rresp_ff} <= {nxt_bresp, nxt_rresp};
			{seq_en_ff, cmpd_ff, cmperr_ff, loaded_ff} <=
				{nxt_seq_en, nxt_cmpd, nxt_cmperr, nxt_loaded};
			proglen_ff <= nxt_proglen;
			{tblidx_ff, w0_ff, tgain_ff, tang_ff} <= {nxt_tblidx, nxt_w0, nxt_tgain, nxt_tang};
			{wslot_ff, manang_ff} <= {nxt_wslot, nxt_manang};
		end
	end

	// table and slot definitions; compile wipes both so stale entries never run
	always_ff @(posedge aclk)
	begin
		if (!aresetn | do_compile)
		begin
			ent_def_ff  <= '0; // R10
			slot_def_ff <= '0;
		end
		else
		begin
			if (do_commit)
				ent_def_ff[tblidx_ff[IW-1:0]] <= 1'b1;
			if (do_bind)
				slot_def_ff[wmerge[SLOT_W-1:0]] <= 1'b1; // R6
		end
	end

	always_ff @(posedge aclk)
	begin
		if (do_commit)
			tbl_mem[tblidx_ff[IW-1:0]] <= {w0_ff[W0_AINC +: 2], w0_ff[W0_AEN +: 2],
				w0_ff[W0_GINC +: 2], w0_ff[W0_GEN +: 2], w0_ff[W0_PLAY],
				w0_ff[W0_SLOT +: SLOT_W], tgain_ff, tang_ff};
	end

	// sample writes carry the slot index as their target address
	assign fin.valid = wr_fire & is_wdata;
	assign fin.data  = {wslot_ff[SLOT_W-1:0], w_data_ff}; // R7
	assign fout.ready = wave_wr_ready;

	pctu_fifo #(.W(FW), .DEPTH(FDEPTH)) u_fifo (
		.aclk    (aclk),
		.aresetn (aresetn),
		.in_s    (fin),
		.out_s   (fout)
	);

	// instruction decode; the entry read is combinational so it completes in one cycle
	always_comb
	begin
		ent     = tbl_mem[instr_operand[IW-1:0]];
		ent_def = (32'(instr_operand) < ENTRIES) && ent_def_ff[instr_operand[IW-1:0]]; // R4
		op_val  = instr_operand[15:0];
		run_acc = instr_valid & ready_ff & (instr_op == OP_RUN);
		dp_acc  = instr_valid & ready_ff & (instr_op == OP_PLAY);
		ld_acc  = instr_valid & ready_ff & (instr_op == OP_LDPH);
		st_acc  = instr_valid & ready_ff & (instr_op == OP_STPH);
		run_ok  = run_acc & loaded_ff & ent_def
			& (~ent.play | ((32'(ent.slot) < SLOTS) && slot_def_ff[ent.slot])); // R9
		dp_ok   = (32'(dp_slot_ff) < SLOTS) && slot_def_ff[dp_slot_ff];
		en_rise = seq_en_ff & ~en_prev_ff;
		// ready held low one cycle after a direct op so two starts never collide
		nxt_ready   = nxt_seq_en & ~dp_acc;
		nxt_dp_pend = dp_acc; // R2
		nxt_dp_slot = dp_acc ? instr_operand[SLOT_W-1:0] : dp_slot_ff;
		nxt_play    = (run_ok & ent.play) | (dp_pend_ff & dp_ok); // R1 R2
		nxt_pslot   = run_ok ? ent.slot : (dp_pend_ff ? dp_slot_ff : pslot_ff);
		// a refusal in the clearing cycle survives
		nxt_refused = (run_acc & ~run_ok) | (dp_pend_ff & ~dp_ok) | (refused_ff & ~clr_refused);
	end

	// per-channel gain, angle and pending step; values persist until changed
	for (genvar ch = 0; ch < 2; ch++)
	begin : g_chan
		logic [15:0] base;
		always_comb
		begin
			base = angle_ff[ch] + (playback_done ? step_ff[ch] : 16'h0000); // R16 R15
			nxt_step[ch] = playback_done ? 16'h0000 : step_ff[ch];
			if (st_acc & (instr_operand[16] == 1'(ch)))
				nxt_step[ch] = nxt_step[ch] + op_val; // R16
			nxt_gain[ch] = gain_ff[ch]; // R11 R12
			if (run_ok & ent.g_en[ch])
				nxt_gain[ch] = ent.g_inc[ch] ? gain_ff[ch] + ent.gain[ch] : ent.gain[ch]; // R3
			nxt_angle[ch] = base; // R11
			if (en_rise)
			begin
				nxt_angle[ch] = loaded_ff ? ANGLE_RST : manang_ff[16*ch +: 16]; // R14 R13
				nxt_step[ch]  = 16'h0000;
			end
			else if (ld_acc & (instr_operand[16] == 1'(ch)))
				nxt_angle[ch] = op_val;
			else if (run_ok & ent.a_en[ch])
				nxt_angle[ch] = ent.a_inc[ch] ? base + ent.angle[ch] : ent.angle[ch]; // R3 R15
		end
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				gain_ff[ch]  <= GAIN_RST;
				angle_ff[ch] <= ANGLE_RST;
				step_ff[ch]  <= 16'h0000;
			end
			else
			begin
				gain_ff[ch]  <= nxt_gain[ch];
				angle_ff[ch] <= nxt_angle[ch];
				step_ff[ch]  <= nxt_step[ch];
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			{play_ff, ready_ff, refused_ff, dp_pend_ff, en_prev_ff} <= 5'h0;
			{pslot_ff, dp_slot_ff} <= '0;
		end
		else
		begin
			{play_ff, ready_ff, refused_ff, dp_pend_ff} <= {nxt_play, nxt_ready, nxt_refused, nxt_dp_pend};
			en_prev_ff <= seq_en_ff;
			{pslot_ff, dp_slot_ff} <= {nxt_pslot, nxt_dp_slot};
		end
	end

	// all outputs straight from flops
	assign {s_axi_awready, s_axi_wready, s_axi_arready} = {awready_ff, wready_ff, arready_ff};
	assign {s_axi_bvalid, s_axi_bresp, s_axi_rvalid, s_axi_rresp} =
		{bvalid_ff, bresp_ff, rvalid_ff, rresp_ff};
	assign s_axi_rdata = rdata_ff;
	assign {instr_ready, play_start, play_slot} = {ready_ff, play_ff, pslot_ff};
	assign {first_channel_gain, second_channel_gain} = {gain_ff[0], gain_ff[1]};
	assign {first_channel_angle, second_channel_angle} = {angle_ff[0], angle_ff[1]};
	assign {wave_wr_valid, wave_wr_slot, wave_wr_sample} = {fout.valid, fout.data};

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_run_one;
		run_ok && ent.play |=> play_start && play_slot == $past(ent.slot);
	endproperty
	a_run_one: assert property (p_run_one) else $error("entry playback not started next cycle"); // R1
	property p_direct_two;
		dp_acc ##1 dp_ok |=> play_start && play_slot == $past(dp_slot_ff);
	endproperty
	a_direct_two: assert property (p_direct_two) else $error("direct playback not at cycle two"); // R2
	property p_gain_inc;
		run_ok && ent.g_en[0] && ent.g_inc[0]
			|=> first_channel_gain == 16'($past(gain_ff[0]) + $past(ent.gain[0]));
	endproperty
	a_gain_inc: assert property (p_gain_inc) else $error("gain increment wrong"); // R3
	property p_refuse;
		run_acc && !run_ok |=> !play_start && refused_ff;
	endproperty
	a_refuse: assert property (p_refuse) else $error("bad entry not refused"); // R9
	property p_prog_limit;
		do_compile && 32'(proglen_ff) > PROG_MAX_INSTR |=> !cmpd_ff && cmperr_ff;
	endproperty
	a_prog_limit: assert property (p_prog_limit) else $error("oversize program compiled"); // R5
	property p_compile_clear;
		do_compile |=> !loaded_ff && ent_def_ff == '0;
	endproperty
	a_compile_clear: assert property (p_compile_clear) else $error("table survived compile"); // R10
	property p_other_gain;
		run_ok && ent.g_en[0] && !ent.g_en[1] |=> $stable(second_channel_gain);
	endproperty
	a_other_gain: assert property (p_other_gain) else $error("untouched gain changed"); // R12
	property p_enable_zero;
		en_rise && loaded_ff |=> first_channel_angle == 16'h0000 && second_channel_angle == 16'h0000;
	endproperty
	a_enable_zero: assert property (p_enable_zero) else $error("angles not cleared on enable"); // R14
	property p_step_wait;
		!playback_done && !en_rise && !ld_acc && !run_ok |=> $stable(first_channel_angle);
	endproperty
	a_step_wait: assert property (p_step_wait) else $error("angle moved before playback end"); // R16
endmodule // pctu_unit
`default_nettype wire

// file: include/pctu_pkg.sv
// constants, types and register map of the pulse command table unit
package pctu_pkg;
	// capacities
	localparam int unsigned PROG_MAX_INSTR = 16384;
	localparam int unsigned WAVE_SLOTS     = 16000;
	localparam int unsigned ENTRY_DEPTH    = 1024;
	localparam int unsigned SLOT_W         = 14;
	localparam int unsigned VAL_W          = 16;
	localparam int unsigned OPND_W         = 17;
	localparam int unsigned FIFO_DEPTH     = 16;
	// timing in core cycles
	localparam int unsigned ENTRY_LAT_CYC  = 1;
	localparam int unsigned DIRECT_LAT_CYC = 2;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_STATUS  = 8'h04;
	localparam logic [7:0] OFS_PROGLEN = 8'h08;
	localparam logic [7:0] OFS_TBLIDX  = 8'h0c;
	localparam logic [7:0] OFS_TBLW0   = 8'h10;
	localparam logic [7:0] OFS_TBLGAIN = 8'h14;
	localparam logic [7:0] OFS_TBLANG  = 8'h18;
	localparam logic [7:0] OFS_COMMIT  = 8'h1c;
	localparam logic [7:0] OFS_BIND    = 8'h20;
	localparam logic [7:0] OFS_WSLOT   = 8'h24;
	localparam logic [7:0] OFS_WDATA   = 8'h28;
	localparam logic [7:0] OFS_GAINRB  = 8'h2c;
	localparam logic [7:0] OFS_ANGRB   = 8'h30;
	localparam logic [7:0] OFS_MANANG  = 8'h34;
	// control and status bit positions
	localparam int unsigned CTRL_EN    = 0;
	localparam int unsigned CTRL_CMP   = 1;
	localparam int unsigned CTRL_LOAD  = 2;
	localparam int unsigned ST_CMPD    = 0;
	localparam int unsigned ST_LOADED  = 1;
	localparam int unsigned ST_REFUSED = 2;
	localparam int unsigned ST_CMPERR  = 3;
	// entry word 0 field positions
	localparam int unsigned W0_SLOT = 0;
	localparam int unsigned W0_PLAY = 16;
	localparam int unsigned W0_GEN  = 17;
	localparam int unsigned W0_GINC = 19;
	localparam int unsigned W0_AEN  = 21;
	localparam int unsigned W0_AINC = 23;
	// reset values and bus response codes
	localparam logic [15:0] GAIN_RST  = 16'h7fff;
	localparam logic [15:0] ANGLE_RST = 16'h0000;
	localparam logic [1:0]  RESP_OK   = 2'h0;
	localparam logic [1:0]  RESP_ERR  = 2'h2;

	typedef enum logic [1:0] {
		OP_RUN   = 2'h0,
		OP_PLAY  = 2'h1,
		OP_LDPH  = 2'h2,
		OP_STPH  = 2'h3
	} pctu_op_e;

	typedef struct packed {
		logic [1:0]        a_inc;
		logic [1:0]        a_en;
		logic [1:0]        g_inc;
		logic [1:0]        g_en;
		logic              play;
		logic [SLOT_W-1:0] slot;
		logic [1:0][15:0]  gain;
		logic [1:0][15:0]  angle;
	} pctu_entry_s;
endpackage

// file: include/pctu_stream_if.sv
// valid/ready word stream between the unit's own modules
`timescale 1ns/10ps
`default_nettype none
interface pctu_stream_if #(parameter int W = 8) ();
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: hdl/pctu_fifo.sv
// show-ahead fifo with registered output stage
`timescale 1ns/10ps
`default_nettype none
module pctu_fifo #(
	parameter int W     = 46,
	parameter int DEPTH = 16
) (
	input  wire logic   aclk,
	input  wire logic   aresetn,
	pctu_stream_if.snk  in_s,
	pctu_stream_if.src  out_s
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
	logic [AW:0]   cnt_ff, nxt_cnt;
	logic          ov_ff, nxt_ov;
	logic [W-1:0]  od_ff, nxt_od;
	logic          push, load;

	// ready drops only when storage is full, so a stalled drain backs up the writer
	assign in_s.ready = (cnt_ff != (AW+1)'(DEPTH));
	assign out_s.valid = ov_ff;
	assign out_s.data  = od_ff;
	assign push = in_s.valid & in_s.ready;
	assign load = (cnt_ff != '0) & (~ov_ff | out_s.ready);

	// pointer and output stage update; depth must be a power of two
	always_comb
	begin
		nxt_wr  = push ? wr_ff + 1'b1 : wr_ff;
		nxt_rd  = load ? rd_ff + 1'b1 : rd_ff;
		nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(load);
		nxt_ov  = load | (ov_ff & ~out_s.ready);
		nxt_od  = load ? mem[rd_ff] : od_ff;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
			ov_ff  <= 1'b0;
			od_ff  <= '0;
		end
		else
		begin
			wr_ff  <= nxt_wr;
			rd_ff  <= nxt_rd;
			cnt_ff <= nxt_cnt;
			ov_ff  <= nxt_ov;
			od_ff  <= nxt_od;
		end
	end

	// storage array, no reset needed
	always_ff @(posedge aclk)
	begin
		if (push)
			mem[wr_ff] <= in_s.data;
	end

	property p_fifo_bound;
		@(posedge aclk) disable iff (!aresetn) cnt_ff <= (AW+1)'(DEPTH);
	endproperty
	a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count above depth");

	property p_fifo_hold;
		@(posedge aclk) disable iff (!aresetn)
			ov_ff && !out_s.ready |=> ov_ff && $stable(od_ff);
	endproperty
	a_fifo_hold: assert property (p_fifo_hold) else $error("fifo output changed while stalled");
endmodule // pctu_fifo
`default_nettype wire

// file: tb/pctu_seq_model.sv
// sequencer-side partner model
`timescale 1ns/10ps
`default_nettype none
module pctu_seq_model
	import pctu_pkg::*;
(
	input  wire logic         aclk,
	input  wire logic         instr_ready,
	input  wire logic         play_start,
	output logic              instr_valid,
	output pctu_op_e          instr_op,
	output logic [OPND_W-1:0] instr_operand,
	output logic              playback_done,
	output logic              wave_wr_ready
);
	logic [1:0] run_ff;
	initial
	begin
		{instr_valid, playback_done, wave_wr_ready, run_ff} = 5'h0;
		instr_op = OP_RUN;
		instr_operand = '0;
	end
	// playback ends four cycles after start; drain stalls at random
	always @(posedge aclk)
	begin
		run_ff <= play_start ? 2'h3 : run_ff - 2'(run_ff != 2'h0);
		playback_done <= run_ff == 2'h1;
		wave_wr_ready <= 1'($urandom_range(1));
	end
	// hold until taken, then scramble the operand
	task automatic issue(input pctu_op_e op, input logic [OPND_W-1:0] v);
		@(posedge aclk);
		instr_valid <= 1'b1;
		instr_op <= op;
		instr_operand <= v;
		do @(posedge aclk); while (instr_ready !== 1'b1);
		instr_valid <= 1'b0;
		instr_operand <= ~v;
	endtask
endmodule // pctu_seq_model
`default_nettype wire

// file: tb/test_pulse_command_table_unit.sv
// self-checking bench of the pulse command table unit
`timescale 1ns/10ps
`default_nettype none
module test_pulse_command_table_unit;
	import pctu_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, wave_wr_sample, rd_v;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic instr_valid, instr_ready, playback_done, play_start, wave_wr_valid, wave_wr_ready;
	pctu_op_e instr_op;
	logic [OPND_W-1:0] instr_operand;
	logic [SLOT_W-1:0] play_slot, wave_wr_slot;
	logic [15:0] first_channel_gain, second_channel_gain, first_channel_angle, second_channel_angle;
	logic [15:0] g0, g1, a0, a1, d0, d1;
	logic [31:0] q[$];
	int fails = 0, samples_checked = 0;
	pctu_unit u_dut (.*);
	pctu_seq_model u_seq (.*);
	always #2 aclk = ~aclk;
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			fails++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask
	// address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", s_axi_bresp, RESP_OK);
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		rd_v = s_axi_rdata;
		chk("rresp", s_axi_rresp, er);
	endtask
	// every drained sample must carry the slot and word written
	always @(posedge aclk)
		if (wave_wr_valid === 1'b1 && wave_wr_ready === 1'b1)
		begin
			chk("wslot", wave_wr_slot, 32'd9);
			chk("wdata", wave_wr_sample, q.pop_front());
		end
	initial
	begin
		#100000;
		fails++;
		final_report;
	end
	initial
	begin
		void'($urandom(16272));
		{g0, g1, a0, a1} = {$urandom, $urandom};
		{d0, d1} = $urandom;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		tick(1);
		wr(OFS_PROGLEN, 32'd16385);
		wr(OFS_CTRL, 32'h2);
		wr(OFS_CTRL, 32'h4);
		rd(OFS_STATUS, RESP_OK);
		chk("toolong", rd_v & 32'hb, 32'h8);
		wr(OFS_PROGLEN, 32'd16384);
		wr(OFS_CTRL, 32'h2);
		wr(OFS_BIND, 32'd5);
		wr(OFS_TBLIDX, 32'd0);
		wr(OFS_TBLW0, 32'h0067_0005);
		wr(OFS_TBLGAIN, {g1, g0});
		wr(OFS_TBLANG, {a1, a0});
		wr(OFS_COMMIT, 32'h0);
		wr(OFS_TBLIDX, 32'd1);
		wr(OFS_TBLW0, 32'h014b_0005);
		wr(OFS_TBLGAIN, {d1, d0});
		wr(OFS_TBLANG, {d1, d0});
		wr(OFS_COMMIT, 32'h0);
		wr(OFS_MANANG, {d0, d1});
		wr(OFS_CTRL, 32'h4);
		wr(OFS_CTRL, 32'h1);
		tick(2);
		chk("en_angle", {first_channel_angle, second_channel_angle}, 32'h0);
		$display("test setup done");
		u_seq.issue(OP_RUN, 17'd0);
		tick(0);
		chk("start", play_start, 1'b1);
		chk("slot", play_slot, 32'd5);
		chk("gain", {second_channel_gain, first_channel_gain}, {g1, g0});
		chk("angle", {second_channel_angle, first_channel_angle}, {a1, a0});
		u_seq.issue(OP_RUN, 17'd1);
		tick(0);
		chk("inc", {second_channel_gain, first_channel_gain}, {g1, g0 + d0});
		chk("wrap", {second_channel_angle, first_channel_angle}, {a1 + d1, a0});
		tick(6);
		u_seq.issue(OP_STPH, 17'h04000);
		tick(2);
		chk("step_wait", first_channel_angle, a0);
		u_seq.issue(OP_PLAY, 17'd5);
		tick(0);
		chk("direct1", play_start, 1'b0);
		tick(1);
		chk("direct2", play_start, 1'b1);
		tick(8);
		chk("step_done", first_channel_angle, 16'(a0 + 16'h4000));
		u_seq.issue(OP_LDPH, {1'b1, d0});
		tick(0);
		chk("ldph", second_channel_angle, d0);
		u_seq.issue(OP_RUN, 17'd7);
		tick(0);
		chk("refuse", play_start, 1'b0);
		rd(OFS_STATUS, RESP_OK);
		chk("refused", rd_v & 32'h7, 32'h7);
		rd(OFS_GAINRB, RESP_OK);
		chk("gainrb", rd_v, {g1, 16'(g0 + d0)});
		rd(8'h3c, RESP_ERR);
		chk("unmapped", rd_v, 32'h0);
		$display("test entries done");
		wr(OFS_CTRL, 32'h3);
		rd(OFS_STATUS, RESP_OK);
		chk("recompile", rd_v & 32'h3, 32'h1);
		u_seq.issue(OP_RUN, 17'd0);
		tick(0);
		chk("stale", play_start, 1'b0);
		wr(OFS_WSLOT, 32'd9);
		repeat (20)
		begin
			q.push_back($urandom);
			wr(OFS_WDATA, q[$]);
		end
		tick(80);
		chk("drained", q.size(), 32'd0);
		$display("test samples done");
		final_report;
	end
endmodule // test_pulse_command_table_unit
`default_nettype wire
